// ### arm_servo_expansion.sv
// Overview of operation
// - Channel index set by select; each setting command uses it, then advances.
// - Index advancing past servo 4 wraps to servo 0.
// - Target position is an unsigned byte 0..255 stored per servo.
// - Speed ranges 1..255, 255 fastest; a zero is raised to one.
// - Enabled servo starts moving at once after its position write.
// - After setup all outputs are off; settings stay writable.
// - Outputs-on command with true argument activates all servos once setup has chosen a personality.
// - Per-servo lower limit 0..255, default 50, sets start of travel.
// - Lower limit command uses and advances the channel index.
// - Per-servo upper limit command bounds the top of pulse range.
// - Setup command with arm personality configures the servo controller.
// - Commands arrive over one request path and one answer path.
// - Offers six digital inputs, five analog bytes, three digital outputs; arm passes six inputs and output 0, arm-out inputs 0..3 and all outputs.
// - Servo 0 shoulder, 1 elbow, 2 hand, 3 wrist tilt, 4 wrist rotate.
// - Position 0 gives lower limit, 255 upper limit, scaled between.
// - Upper limit is a percentage 0..100 of range, default 50.
//
// The implementer's own choices: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "arm_servo_defines.svh"
module arm_servo_expansion #(
  parameter int FRAME_US = `FRAME_US,
  parameter int N        = `NUM_SERVOS
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 ce,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire arm_servo_pkg::word_t pwdata,
  output var  arm_servo_pkg::word_t prdata,
  output var  logic                 pready,
  output var  logic                 pslverr,
  input  wire logic [5:0]           din,
  input  wire logic [39:0]          analog_in,
  output var  logic [N-1:0]         servo_out,
  output var  logic [2:0]           dout
);
  import arm_servo_pkg::*;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  localparam chan_t LAST = chan_t'(N - 1);

  chan_t        idx;
  personality_e pers;
  logic         enabled;
  byte_t        pos_q [N], slew_q [N], lower_q [N], upper_q [N];
  logic [2:0]   dout_q;
  logic [N-1:0] moving;
  frame_t       frame_us;
  logic         frame_start;
  logic         wr_en, rvalid, load_rd, mapped;
  word_t        rdata_c;
  cmd_e         op;
  byte_t        arg;
  logic         pos_wr, slew_wr, lower_wr, upper_wr, param_wr;
  logic         select_wr, ctrl_wr, setup_wr, dout_wr;
  logic [5:0]   din_mask;
  logic [2:0]   dout_mask;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic chan_t next_index(input chan_t i);
    return (i == LAST) ? 3'h0 : i + 3'h1;
  endfunction : next_index

  function automatic personality_e pers_of(input logic [1:0] code);
    case (code)
      2'h1:    return PERS_ARM;
      2'h2:    return PERS_ARM_OUT;
      default: return PERS_NONE;
    endcase
  endfunction : pers_of

  // ----------------------------------------
  // Bus handshake
  // ----------------------------------------
  assign wr_en   = ce && psel && penable && pwrite;
  assign load_rd = ce && psel && !pwrite && !rvalid;
  assign pready  = ce && (pwrite || rvalid);
  assign pslverr = psel && penable && pready && !mapped;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rvalid <= 1'b0;
    end else if (load_rd) begin
      rvalid <= 1'b1;
    end else if (psel && penable && pready) begin
      rvalid <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (load_rd) begin
      prdata <= rdata_c;
    end
  end

  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  always_comb begin
    op  = OP_NOP;
    arg = pwdata[7:0];
    if (wr_en) begin
      case (paddr)
        `OFF_CHANNEL:  op = OP_SELECT;
        `OFF_POSITION: op = OP_POSITION;
        `OFF_SLEW:     op = OP_SLEW;
        `OFF_LOWER:    op = OP_LOWER;
        `OFF_UPPER:    op = OP_UPPER;
        `OFF_CONTROL:  op = OP_OUTPUTS_ON;
        `OFF_SETUP:    op = OP_SETUP;
        `OFF_DOUT:     op = OP_DOUT;
        `OFF_CMD:      op = cmd_e'(pwdata[`CMD_OP_LSB +: 4]);
        default:       op = OP_NOP;
      endcase
    end
  end

  assign select_wr = (op == OP_SELECT);
  assign pos_wr    = (op == OP_POSITION);
  assign slew_wr   = (op == OP_SLEW);
  assign lower_wr  = (op == OP_LOWER);
  assign upper_wr  = (op == OP_UPPER);
  assign ctrl_wr   = (op == OP_OUTPUTS_ON);
  assign setup_wr  = (op == OP_SETUP);
  assign dout_wr   = (op == OP_DOUT);
  assign param_wr  = pos_wr || slew_wr || lower_wr || upper_wr;

  // ----------------------------------------
  // Channel index
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idx <= 3'h0;
    end else if (setup_wr) begin
      idx <= 3'h0;
    end else if (select_wr) begin
      idx <= (arg[2:0] > LAST || arg[7:3] != 5'h00) ? 3'h0 : arg[2:0];
    end else if (param_wr) begin
      idx <= next_index(idx);
    end
  end

  // ----------------------------------------
  // Per-servo settings
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < N; i++) begin
        pos_q[i] <= `POS_DEFAULT;
      end
    end else if (pos_wr) begin
      pos_q[idx] <= arg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < N; i++) begin
        slew_q[i] <= `SLEW_DEFAULT;
      end
    end else if (slew_wr) begin
      slew_q[idx] <= (arg == 8'h00) ? `SLEW_FLOOR : arg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < N; i++) begin
        lower_q[i] <= `LOWER_DEFAULT;
      end
    end else if (setup_wr) begin
      for (int i = 0; i < N; i++) begin
        lower_q[i] <= `LOWER_DEFAULT;
      end
    end else if (lower_wr) begin
      lower_q[idx] <= arg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < N; i++) begin
        upper_q[i] <= `UPPER_DEFAULT;
      end
    end else if (setup_wr) begin
      for (int i = 0; i < N; i++) begin
        upper_q[i] <= `UPPER_DEFAULT;
      end
    end else if (upper_wr) begin
      upper_q[idx] <= arg;
    end
  end

  // ----------------------------------------
  // Personality and output enable
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pers    <= PERS_NONE;
      enabled <= 1'b0;
    end else if (setup_wr) begin
      pers    <= pers_of(arg[1:0]);
      enabled <= 1'b0;
    end else if (ctrl_wr) begin
      enabled <= arg[`CTRL_ON_BIT] && (pers != PERS_NONE);
    end
  end

  // ----------------------------------------
  // Digital inputs and outputs
  // ----------------------------------------
  always_comb begin
    case (pers)
      PERS_ARM: begin
        din_mask  = `DIN_MASK_ARM;
        dout_mask = `DOUT_MASK_ARM;
      end
      PERS_ARM_OUT: begin
        din_mask  = `DIN_MASK_OUT;
        dout_mask = `DOUT_MASK_OUT;
      end
      default: begin
        din_mask  = 6'h00;
        dout_mask = 3'h0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dout_q <= 3'h0;
    end else if (setup_wr) begin
      dout_q <= 3'h0;
    end else if (dout_wr) begin
      dout_q <= arg[2:0] & dout_mask;
    end
  end

  assign dout = dout_q;

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always_comb begin
    rdata_c = 32'h0000_0000;
    mapped  = 1'b1;
    case (paddr)
      `OFF_CHANNEL:   rdata_c = 32'(idx);
      `OFF_POSITION:  rdata_c = 32'(pos_q[idx]);
      `OFF_SLEW:      rdata_c = 32'(slew_q[idx]);
      `OFF_LOWER:     rdata_c = 32'(lower_q[idx]);
      `OFF_UPPER:     rdata_c = 32'(upper_q[idx]);
      `OFF_CONTROL:   rdata_c = 32'(enabled);
      `OFF_SETUP:     rdata_c = 32'(pers);
      `OFF_STATUS:    rdata_c = 32'({moving, 2'b00, 2'(pers), enabled, idx});
      `OFF_DIN:       rdata_c = 32'(din & din_mask);
      `OFF_DOUT:      rdata_c = 32'(dout_q);
      `OFF_ANALOG_LO: rdata_c = analog_in[31:0];
      `OFF_ANALOG_HI: rdata_c = 32'(analog_in[39:32]);
      `OFF_CMD:       rdata_c = 32'h0000_0000;
      default:        mapped  = 1'b0;
    endcase
  end

  // ----------------------------------------
  // Servo channels
  // ----------------------------------------
  frame_timer #(
    .US_CYCLES (`US_CYCLES),
    .FRAME_US  (FRAME_US)
  ) u_frame (
    .pclk        (pclk),
    .presetn     (presetn),
    .ce          (ce),
    .frame_us    (frame_us),
    .frame_start (frame_start)
  );

  for (genvar i = 0; i < N; i++) begin : g_servo
    servo_if sv_i ();
    assign sv_i.enable      = enabled;
    assign sv_i.frame_start = frame_start;
    assign sv_i.frame_us    = frame_us;
    assign sv_i.pos         = pos_q[i];
    assign sv_i.lower       = lower_q[i];
    assign sv_i.upper       = upper_q[i];
    assign sv_i.rate        = slew_q[i];
    assign servo_out[i]     = sv_i.pulse;
    assign moving[i]        = sv_i.moving;

    servo_channel u_chan (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .sv      (sv_i)
    );

    chk_pos_store: assert property (
      @(posedge pclk) disable iff (!presetn) pos_wr && idx == chan_t'(i) |=>
        pos_q[i] == $past(arg))
      else $error("position not stored for indexed servo");
    chk_slew_floor: assert property (
      @(posedge pclk) disable iff (!presetn) slew_wr && idx == chan_t'(i) |=>
        slew_q[i] == (($past(arg) == 8'h00) ? 8'h01 : $past(arg)))
      else $error("speed stored wrongly");
    chk_lower_store: assert property (
      @(posedge pclk) disable iff (!presetn) lower_wr && idx == chan_t'(i) |=>
        lower_q[i] == $past(arg))
      else $error("lower limit not stored for indexed servo");
    chk_upper_store: assert property (
      @(posedge pclk) disable iff (!presetn) upper_wr && idx == chan_t'(i) |=>
        upper_q[i] == $past(arg))
      else $error("upper limit not stored for indexed servo");
    chk_setup_limits: assert property (
      @(posedge pclk) disable iff (!presetn) setup_wr |=>
        lower_q[i] == 8'h32 && upper_q[i] == 8'h32)
      else $error("limits not defaulted by setup");
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_setup_then_run;
    setup_wr ##1 ce;
  endsequence
  sequence s_on_cmd;
    ctrl_wr && arg[0] && pers != PERS_NONE;
  endsequence
  chk_index_step: assert property (
    @(posedge pclk) disable iff (!presetn) param_wr && idx != LAST |=>
      idx == chan_t'($past(idx) + 3'h1))
    else $error("index did not advance by one");
  chk_index_wrap: assert property (
    @(posedge pclk) disable iff (!presetn) param_wr && idx == LAST |=> idx == 3'h0)
    else $error("index did not wrap to servo zero");
  chk_init_off: assert property (
    @(posedge pclk) disable iff (!presetn) s_setup_then_run |->
      !enabled ##1 servo_out == '0)
    else $error("outputs active after setup");
  chk_enable_cmd: assert property (
    @(posedge pclk) disable iff (!presetn) s_on_cmd |=> enabled ##1 (enabled || $past(ctrl_wr || setup_wr)))
    else $error("outputs-on command ignored");
  chk_arm_setup: assert property (
    @(posedge pclk) disable iff (!presetn) setup_wr && arg[1:0] == 2'h1 |=> pers == PERS_ARM)
    else $error("arm personality not taken");
  chk_dout_mask: assert property (
    @(posedge pclk) disable iff (!presetn) pers != PERS_ARM_OUT |-> dout[2:1] == 2'b00)
    else $error("unavailable output bit driven");
  chk_off_quiet: assert property (
    @(posedge pclk) disable iff (!presetn) !enabled && ce |=> servo_out == '0)
    else $error("pulse while disabled");
endmodule : arm_servo_expansion
`default_nettype wire

// ### arm_servo_defines.svh
`ifndef ARM_SERVO_DEFINES_SVH
`define ARM_SERVO_DEFINES_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFF_CHANNEL   8'h00
`define OFF_POSITION  8'h04
`define OFF_SLEW      8'h08
`define OFF_LOWER     8'h0C
`define OFF_UPPER     8'h10
`define OFF_CONTROL   8'h14
`define OFF_SETUP     8'h18
`define OFF_STATUS    8'h1C
`define OFF_DIN       8'h20
`define OFF_DOUT      8'h24
`define OFF_ANALOG_LO 8'h28
`define OFF_ANALOG_HI 8'h2C
`define OFF_CMD       8'h30

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define CMD_OP_LSB     8
`define CTRL_ON_BIT    0
`define NUM_SERVOS     5
`define POS_DEFAULT    8'h80
`define SLEW_DEFAULT   8'h0A
`define SLEW_FLOOR     8'h01
`define LOWER_DEFAULT  8'h32
`define UPPER_DEFAULT  8'h32
`define DIN_MASK_ARM   6'h3F
`define DIN_MASK_OUT   6'h0F
`define DOUT_MASK_ARM  3'h1
`define DOUT_MASK_OUT  3'h7

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS  10
`define US_NS          1000
`define US_CYCLES      (`US_NS / `CLK_PERIOD_NS)
`define FRAME_TIME_MS  20
`define FRAME_US       (`FRAME_TIME_MS * 1000)
`define PULSE_BASE_US  500
`define LOWER_STEP_US  4
`define UPPER_STEP_US  20

`endif

// ### arm_servo_pkg.sv
package arm_servo_pkg;
  typedef logic [31:0] word_t;
  typedef logic [7:0]  byte_t;
  typedef logic [2:0]  chan_t;
  typedef logic [12:0] width_t;
  typedef logic [14:0] frame_t;
  typedef enum logic [1:0] {PERS_NONE, PERS_ARM, PERS_ARM_OUT} personality_e;
  typedef enum logic [3:0] {
    OP_NOP, OP_SELECT, OP_POSITION, OP_SLEW, OP_LOWER,
    OP_UPPER, OP_OUTPUTS_ON, OP_SETUP, OP_DOUT
  } cmd_e;
endpackage : arm_servo_pkg

// ### servo_if.sv
`timescale 1ns/1ps
`default_nettype none
interface servo_if;
  import arm_servo_pkg::*;
  logic   enable;
  logic   frame_start;
  frame_t frame_us;
  byte_t  pos;
  byte_t  lower;
  byte_t  upper;
  byte_t  rate;
  logic   pulse;
  logic   moving;
  modport ctrl (output enable, frame_start, frame_us, pos, lower, upper, rate,
                input pulse, moving);
  modport chan (input enable, frame_start, frame_us, pos, lower, upper, rate,
                output pulse, moving);
endinterface : servo_if
`default_nettype wire

// ### frame_timer.sv
`timescale 1ns/1ps
`default_nettype none
module frame_timer #(
  parameter int US_CYCLES = 100,
  parameter int FRAME_US  = 20000
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  ce,
  output var  arm_servo_pkg::frame_t frame_us,
  output var  logic                  frame_start
);
  import arm_servo_pkg::*;
  logic [7:0] presc;
  logic       us_tick;
  assign us_tick = (presc == 8'(US_CYCLES - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc <= 8'h00;
    end else if (ce) begin
      presc <= us_tick ? 8'h00 : presc + 8'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_us    <= 15'h0000;
      frame_start <= 1'b0;
    end else if (ce) begin
      frame_start <= us_tick && (frame_us == frame_t'(FRAME_US - 1));
      if (us_tick) begin
        frame_us <= (frame_us == frame_t'(FRAME_US - 1)) ? 15'h0000 : frame_us + 15'h0001;
      end
    end
  end

  chk_frame_origin: assert property (
    @(posedge pclk) disable iff (!presetn) frame_start |-> frame_us == 15'h0000)
    else $error("frame start away from frame origin");
endmodule : frame_timer
`default_nettype wire

// ### servo_channel.sv
`include "arm_servo_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module servo_channel (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  servo_if.chan    sv
);
  import arm_servo_pkg::*;
  width_t      lo;
  width_t      span;
  width_t      tgt;
  width_t      cur;
  width_t      rate_w;
  logic [21:0] prod;

  // ----------------------------------------
  // Target width from position and limits
  // ----------------------------------------
  assign lo     = width_t'(`PULSE_BASE_US) + width_t'({sv.lower, 2'b00});
  assign span   = width_t'(32'(sv.upper) * `UPPER_STEP_US);
  assign prod   = 22'(span) * 22'({1'b0, sv.pos} + 9'(sv.pos[7]));
  assign tgt    = lo + width_t'(prod[21:8]);
  assign rate_w = width_t'(sv.rate);
  assign sv.moving = (cur != tgt);

  // ----------------------------------------
  // Stepwise slew and pulse output
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur <= width_t'(`PULSE_BASE_US);
    end else if (ce) begin
      if (!sv.enable) begin
        cur <= tgt;
      end else if (sv.frame_start) begin
        if (cur < tgt) begin
          cur <= (tgt - cur > rate_w) ? cur + rate_w : tgt;
        end else if (cur > tgt) begin
          cur <= (cur - tgt > rate_w) ? cur - rate_w : tgt;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sv.pulse <= 1'b0;
    end else if (ce) begin
      sv.pulse <= sv.enable && (sv.frame_us < 15'(cur));
    end
  end

  chk_full_scale: assert property (
    @(posedge pclk) disable iff (!presetn) sv.pos == 8'hFF |-> tgt == lo + span)
    else $error("full position misses upper limit");
  chk_step_bound: assert property (
    @(posedge pclk) disable iff (!presetn) ce && sv.frame_start && sv.enable |=>
      ((cur >= $past(cur)) ? cur - $past(cur) : $past(cur) - cur) <= width_t'($past(sv.rate)))
    else $error("width step exceeds rate");
  chk_hold_between: assert property (
    @(posedge pclk) disable iff (!presetn) ce && sv.enable && !sv.frame_start |=>
      cur == $past(cur))
    else $error("width moved outside frame start");
endmodule : servo_channel
`default_nettype wire

// ### servo_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Servo pulse monitor
// ----------------------------------------
module servo_monitor (
  input  wire logic       pclk,
  input  wire logic       clear,
  input  wire logic [4:0] servo_out,
  output var  logic [4:0] seen_high
);
  // Sticky record of channels that drove a pulse
  always_ff @(posedge pclk) begin
    if (clear) begin
      seen_high <= 5'h00;
    end else begin
      seen_high <= seen_high | servo_out;
    end
  end
endmodule : servo_monitor
`default_nettype wire

// ### arm_servo_expansion_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "arm_servo_defines.svh"
module arm_servo_expansion_tb;
  import arm_servo_pkg::*;
  logic        pclk, presetn, ce, psel, penable, pwrite, clear, pready, pslverr, err;
  logic [7:0]  paddr;
  word_t       pwdata, prdata, rd;
  logic [5:0]  din;
  logic [39:0] analog_in;
  logic [4:0]  servo_out, seen;
  logic [2:0]  dout;
  int          miscompares, checked, idx, pers, on, dv, i, c;
  int          pos[5], spd[5], lo[5], up[5];

  arm_servo_expansion #(.FRAME_US(50), .N(5)) dut (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .din(din), .analog_in(analog_in),
    .servo_out(servo_out), .dout(dout));
  servo_monitor mon (.pclk(pclk), .clear(clear), .servo_out(servo_out), .seen_high(seen));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // ----------------------------------------
  // Reference model
  // ----------------------------------------
  task automatic model_wr(input logic [7:0] wa, input word_t wd);
    logic [7:0] op_a[$];
    logic [7:0] a;
    word_t      d;
    a = wa;
    d = wd;
    op_a = '{8'h34, `OFF_CHANNEL, `OFF_POSITION, `OFF_SLEW, `OFF_LOWER, `OFF_UPPER,
             `OFF_CONTROL, `OFF_SETUP, `OFF_DOUT};
    if (wa == `OFF_CMD) begin
      a = (wd[11:8] < 4'h9) ? op_a[wd[11:8]] : 8'h34;
      d = {24'h0, wd[7:0]};
    end
    case (a)
      `OFF_CHANNEL:  idx = (d[7:0] > 4) ? 0 : d[7:0];
      `OFF_POSITION: pos[idx] = d[7:0];
      `OFF_SLEW:     spd[idx] = (d[7:0] == 0) ? 1 : d[7:0];
      `OFF_LOWER:    lo[idx] = d[7:0];
      `OFF_UPPER:    up[idx] = d[7:0];
      `OFF_CONTROL:  on = d[0] && pers != 0;
      `OFF_DOUT:     dv = d[2:0] & (pers == 1 ? 1 : pers == 2 ? 7 : 0);
      `OFF_SETUP: begin
        pers = (d[1:0] == 1) ? 1 : (d[1:0] == 2) ? 2 : 0;
        on = 0;
        idx = 0;
        dv = 0;
        lo = '{5{50}};
        up = '{5{50}};
      end
      default: ;
    endcase
    if (a >= `OFF_POSITION && a <= `OFF_UPPER) idx = (idx + 1) % 5;
  endtask : model_wr

  function automatic word_t exp_rd(input logic [7:0] a);
    case (a)
      `OFF_CHANNEL:   return idx;
      `OFF_POSITION:  return pos[idx];
      `OFF_SLEW:      return spd[idx];
      `OFF_LOWER:     return lo[idx];
      `OFF_UPPER:     return up[idx];
      `OFF_SETUP:     return pers;
      `OFF_STATUS:    return idx + on * 8 + pers * 16;
      `OFF_DIN:       return din & (pers == 1 ? 6'h3F : pers == 2 ? 6'h0F : 6'h00);
      `OFF_DOUT:      return dv;
      `OFF_ANALOG_LO: return analog_in[31:0];
      `OFF_ANALOG_HI: return {24'h0, analog_in[39:32]};
      default:        return 32'h0;
    endcase
  endfunction : exp_rd

  // ----------------------------------------
  // Bus and check tasks
  // ----------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input string what, input word_t seen_v, input word_t exp_v);
    checked++;
    if (seen_v !== exp_v) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp_v, seen_v);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a, input word_t d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      miscompares++;
      report_and_stop();
    end
    err = pslverr;
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (wr) model_wr(a, d);
  endtask : apb

  task automatic rdchk(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
    chk($sformatf("read %h", a), (a == `OFF_STATUS && on) ? rd & 32'hFF : rd, exp_rd(a));
    chk($sformatf("pslverr %h", a), {31'h0, err}, {31'h0, a > `OFF_CMD});
  endtask : rdchk

  task automatic readall();
    for (int k = 0; k < 5; k++) begin
      apb(1'b1, `OFF_CHANNEL, k);
      for (int r = 1; r < 5; r++) rdchk(8'(4 * r));
    end
  endtask : readall

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, din, analog_in} = '0;
    ce = 1'b1;
    clear = 1'b1;
    void'($urandom(32'h51B0));
    pos = '{5{128}};
    spd = '{5{10}};
    lo = '{5{50}};
    up = '{5{50}};
    {idx, pers, on, dv} = '0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    readall();
    apb(1'b1, `OFF_SETUP, 1);
    rdchk(`OFF_SETUP);
    apb(1'b1, `OFF_CHANNEL, 3);
    for (i = 0; i < 6; i++) apb(1'b1, `OFF_POSITION, $urandom_range(255));
    rdchk(`OFF_CHANNEL);
    for (i = 0; i < 5; i++) apb(1'b1, `OFF_SLEW, (i == 2) ? 0 : $urandom_range(255, 1));
    for (i = 0; i < 5; i++) apb(1'b1, `OFF_LOWER, $urandom_range(255));
    for (i = 0; i < 5; i++) apb(1'b1, `OFF_UPPER, $urandom_range(100));
    readall();
    apb(1'b1, `OFF_CHANNEL, 7);
    rdchk(`OFF_CHANNEL);
    for (c = 0; c < 10; c++) begin
      apb(1'b1, `OFF_CMD, {20'h0, 4'(c), (c == 6) ? 8'h01 : 8'($urandom)});
      rdchk(`OFF_STATUS);
    end
    fork
      rdchk(`OFF_STATUS);
      begin
        ce <= 1'b0;
        repeat (3) @(posedge pclk);
        ce <= 1'b1;
      end
    join
    readall();
    apb(1'b1, `OFF_SETUP, 1);
    clear <= 1'b0;
    repeat (6000) @(posedge pclk);
    chk("outputs before enable", seen, 0);
    apb(1'b1, `OFF_CONTROL, 1);
    clear <= 1'b1;
    @(posedge pclk);
    clear <= 1'b0;
    repeat (12000) @(posedge pclk);
    chk("outputs after enable", seen, 5'h1F);
    apb(1'b1, `OFF_SETUP, 1);
    clear <= 1'b1;
    @(posedge pclk);
    clear <= 1'b0;
    repeat (20) @(posedge pclk);
    chk("outputs after setup", seen, 0);
    for (c = 0; c < 3; c++) begin
      apb(1'b1, `OFF_SETUP, c);
      din <= 6'($urandom);
      analog_in <= {8'($urandom), 32'($urandom)};
      apb(1'b1, `OFF_DOUT, $urandom_range(7));
      for (i = 8; i < 12; i++) rdchk(8'(4 * i));
      chk("dout pins", dout, dv);
      apb(1'b1, `OFF_CONTROL, 1);
      rdchk(`OFF_STATUS);
    end
    apb(1'b1, 8'h34, 32'hFF);
    rdchk(8'h34);
    rdchk(`OFF_CMD);
    readall();
    report_and_stop();
  end
endmodule : arm_servo_expansion_tb
`default_nettype wire
